// ==== inc/eprx_map.vh ====
// register offsets, field positions, reset values and frame layout constants
`ifndef EPRX_MAP_VH
`define EPRX_MAP_VH
`define EPRX_OFF_CTRL      12'h000
`define EPRX_OFF_LENFILT   12'h004
`define EPRX_OFF_SKIP      12'h008
`define EPRX_OFF_PKTCNT    12'h00c
`define EPRX_OFF_FCSERR    12'h010
`define EPRX_OFF_DROPCNT   12'h014
`define EPRX_OFF_SRCBASE   12'h040
`define EPRX_OFF_SRCLAST   12'h0bc
`define EPRX_CTRL_RAW      0
`define EPRX_CTRL_CRCDIS   2
`define EPRX_CTRL_PROMISC  4
`define EPRX_CTRL_RESET    32'h0000_0010
`define EPRX_LEN_EN        31
`define EPRX_SRC_EN        16
`define EPRX_PRE_BYTES     14'h0008
`define EPRX_HDR_END       14'h0016
`define EPRX_SRC_FIRST     14'h000e
`define EPRX_FCS_BYTES     14'h0004
`define EPRX_CRC_INIT      32'hffff_ffff
`define EPRX_CRC_POLY      32'hedb8_8320
`define EPRX_CRC_RESIDUE   32'hdebb_20e3
`define EPRX_BUF_AW        13
`define EPRX_SRC_NUM       16
`endif

// ==== rtl/eprx_recorder_rx.v ====
// receive-side payload extractor with apb registers and packet buffer
`timescale 1ns/1ps
`include "eprx_map.vh"

// Contract
// - every packet holds exactly one frame
// - preamble 8, header 14, client data, FCS 4
// - record from skip offset, never the FCS
// - skip counts from first client byte
// - zero skip records whole client data
// - jumbo packets up to 9000 bytes accepted
// - raw mode records everything after header except the FCS
// - raw mode pads to next 8 bytes
// - filter on source address and/or length
// - buffer holds seven jumbo packets
// - FCS only checks, never recorded
// - passive receiver, never answers requests
// - bad FCS withholds payload when checking (raw mode records it anyway, even with the check enabled)
// - raw mode ignores other filter settings
// - 16-bit length against client data size
// - up to sixteen enabled source addresses
module eprx_recorder_rx
(
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rxValid,
  input  wire [7:0]  rxData,
  input  wire        rxLast,
  output reg  [63:0] recData,
  output reg         recValid,
  input  wire        recReady
);

  localparam AW    = `EPRX_BUF_AW;
  localparam DEPTH = 1 << AW;
  localparam SN    = `EPRX_SRC_NUM;

  // one crc byte step, reflected polynomial
  function [31:0] crcStep;
    input [31:0] c;
    input [7:0]  b;
    integer      k;
    reg [31:0]   t;
    begin
      t = c ^ {24'h00_0000, b};
      for (k = 0; k < 8; k = k + 1)
        t = t[0] ? ((t >> 1) ^ `EPRX_CRC_POLY) : (t >> 1);
      crcStep = t;
    end
  endfunction

  // register file
  reg  [31:0] ctrl_q;
  reg  [31:0] lenFilt_q;
  reg  [15:0] skip_q;
  reg  [31:0] pktCnt_q;
  reg  [31:0] fcsErr_q;
  reg  [31:0] dropCnt_q;
  reg  [31:0] srcLo_q [0:SN-1];
  reg  [16:0] srcHi_q [0:SN-1];
  reg  [31:0] rdMux;
  reg         addrOk;
  wire        apbWr = psel & penable & pready & pwrite;
  wire [3:0]  srcIdx = paddr[6:3];
  wire        srcSpace = (paddr >= `EPRX_OFF_SRCBASE) && (paddr <= `EPRX_OFF_SRCLAST);

  // datapath state
  reg  [13:0] pos_q;
  reg  [31:0] dly_q;
  reg  [31:0] crc_q;
  reg  [47:0] srcMac_q;
  reg  [13:0] clientLen_q;
  reg  [63:0] word_q;
  reg  [2:0]  lane_q;
  reg         endPend_q;
  reg         crcBad_q;
  reg         ovf_q;
  reg  [AW:0] wrTent_q;
  reg  [AW:0] wrCommit_q;
  reg  [AW:0] rd_q;
  reg  [63:0] mem [0:DEPTH-1];

  // read decode, shared by every apb read
  always @*
  begin
    rdMux = 32'h0000_0000;
    addrOk = 1'b1;
    if (srcSpace)
      rdMux = paddr[2] ? {15'h0000, srcHi_q[srcIdx]} : srcLo_q[srcIdx];
    else
      case (paddr)
        `EPRX_OFF_CTRL:    rdMux = ctrl_q;
        `EPRX_OFF_LENFILT: rdMux = lenFilt_q;
        `EPRX_OFF_SKIP:    rdMux = {16'h0000, skip_q};
        `EPRX_OFF_PKTCNT:  rdMux = pktCnt_q;
        `EPRX_OFF_FCSERR:  rdMux = fcsErr_q;
        `EPRX_OFF_DROPCNT: rdMux = dropCnt_q;
        default:           addrOk = 1'b0;
      endcase
  end

  // apb handshake: no wait states, answer registered in the setup cycle
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? rdMux : 32'h0000_0000;
      pslverr <= psel & ~penable & ~addrOk;
    end
  end

  // address table, generate keeps the sixteen slots uniform
  genvar g;
  generate
    for (g = 0; g < SN; g = g + 1)
    begin : gSrc
      always @(posedge clk_sys)
      begin
        if (!resetn)
        begin
          srcLo_q[g] <= 32'h0000_0000;
          srcHi_q[g] <= 17'h0_0000;
        end
        else if (apbWr && srcSpace && srcIdx == g)
        begin
          if (paddr[2])
            srcHi_q[g] <= pwdata[16:0];
          else
            srcLo_q[g] <= pwdata;
        end
      end
    end
  endgenerate

  // source address hit against any enabled slot
  reg srcHit;
  integer s;
  always @*
  begin
    srcHit = 1'b0;
    for (s = 0; s < SN; s = s + 1)
      if (srcHi_q[s][`EPRX_SRC_EN] && srcMac_q == {srcHi_q[s][15:0], srcLo_q[s]})
        srcHit = 1'b1;
  end

  // byte leaving the four-byte delay is never part of the fcs
  wire [13:0] outIdx   = pos_q - `EPRX_FCS_BYTES;
  wire        emitOk   = rxValid && (pos_q >= `EPRX_FCS_BYTES);
  wire [7:0]  outByte  = dly_q[7:0];
  wire        rawMode  = ctrl_q[`EPRX_CTRL_RAW];
  wire [15:0] skipEff  = rawMode ? 16'h0000 : skip_q;
  wire [13:0] clientIx = outIdx - `EPRX_HDR_END;
  wire        isClient = emitOk && (outIdx >= `EPRX_HDR_END);
  wire        recByte  = isClient && ({2'b00, clientIx} >= skipEff);
  wire [AW:0] used     = wrTent_q - rd_q;
  wire        full     = used[AW];

  // accept decision once the last byte is in; raw bypasses all filters
  wire crcPass = ~crcBad_q | ctrl_q[`EPRX_CTRL_CRCDIS];
  wire srcPass = ctrl_q[`EPRX_CTRL_PROMISC] | srcHit;
  wire lenPass = ~lenFilt_q[`EPRX_LEN_EN] | (lenFilt_q[15:0] == {2'b00, clientLen_q});
  wire accept  = ~ovf_q & (rawMode | (crcPass & srcPass & lenPass));

  // packet parse, crc, word assembly and commit
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pos_q <= 14'h0000;
      dly_q <= 32'h0000_0000;
      crc_q <= `EPRX_CRC_INIT;
      srcMac_q <= 48'h0000_0000_0000;
      clientLen_q <= 14'h0000;
      word_q <= 64'h0000_0000_0000_0000;
      lane_q <= 3'h0;
      endPend_q <= 1'b0;
      crcBad_q <= 1'b0;
      ovf_q <= 1'b0;
      wrTent_q <= {(AW+1){1'b0}};
      wrCommit_q <= {(AW+1){1'b0}};
    end
    else
    begin
      endPend_q <= 1'b0;
      if (rxValid)
      begin
        dly_q <= {rxData, dly_q[31:8]};
        if (pos_q >= `EPRX_PRE_BYTES)
          crc_q <= crcStep(crc_q, rxData);
        // a 14-bit index covers jumbo frames with room to spare
        pos_q <= rxLast ? 14'h0000 : pos_q + 14'h0001;
        if (rxLast)
        begin
          endPend_q <= 1'b1;
          crcBad_q <= (crcStep(crc_q, rxData) != `EPRX_CRC_RESIDUE);
          clientLen_q <= pos_q + 14'h0001 - `EPRX_HDR_END - `EPRX_FCS_BYTES;
          crc_q <= `EPRX_CRC_INIT;
        end
      end
      // capture the source address as it leaves the delay line
      if (emitOk && outIdx >= `EPRX_SRC_FIRST && outIdx < `EPRX_SRC_FIRST + 14'h0006)
        srcMac_q <= {srcMac_q[39:0], outByte};
      // pack bytes little-endian into 8-byte words
      if (recByte)
      begin
        word_q[lane_q*8 +: 8] <= outByte;
        lane_q <= lane_q + 3'h1;
        if (lane_q == 3'h7)
        begin
          // start the next word clean, else a short tail would pad with stale bytes
          word_q <= 64'h0000_0000_0000_0000;
          if (full)
            ovf_q <= 1'b1;
          else
          begin
            mem[wrTent_q[AW-1:0]] <= {outByte, word_q[55:0]};
            wrTent_q <= wrTent_q + 1'b1;
          end
        end
      end
      if (endPend_q)
      begin
        lane_q <= 3'h0;
        word_q <= 64'h0000_0000_0000_0000;
        ovf_q <= 1'b0;
        if (accept)
        begin
          // tail word padded with zeros up to the next 8 bytes
          if (lane_q != 3'h0 && !full)
          begin
            mem[wrTent_q[AW-1:0]] <= word_q;
            wrTent_q <= wrTent_q + 1'b1;
            wrCommit_q <= wrTent_q + 1'b1;
          end
          else
            wrCommit_q <= wrTent_q;
        end
        else
          wrTent_q <= wrCommit_q;
      end
    end
  end

  // counters; software clears by writing any value, a same-cycle count still wins
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pktCnt_q <= 32'h0000_0000;
      fcsErr_q <= 32'h0000_0000;
      dropCnt_q <= 32'h0000_0000;
    end
    else
    begin
      if (endPend_q)
        pktCnt_q <= (apbWr && paddr == `EPRX_OFF_PKTCNT) ? 32'h0000_0001 : pktCnt_q + 32'h0000_0001;
      else if (apbWr && paddr == `EPRX_OFF_PKTCNT)
        pktCnt_q <= 32'h0000_0000;
      if (endPend_q && crcBad_q)
        fcsErr_q <= (apbWr && paddr == `EPRX_OFF_FCSERR) ? 32'h0000_0001 : fcsErr_q + 32'h0000_0001;
      else if (apbWr && paddr == `EPRX_OFF_FCSERR)
        fcsErr_q <= 32'h0000_0000;
      if (endPend_q && !accept)
        dropCnt_q <= (apbWr && paddr == `EPRX_OFF_DROPCNT) ? 32'h0000_0001 : dropCnt_q + 32'h0000_0001;
      else if (apbWr && paddr == `EPRX_OFF_DROPCNT)
        dropCnt_q <= 32'h0000_0000;
    end
  end

  // configuration registers; skip is held by software during a session
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ctrl_q <= `EPRX_CTRL_RESET;
      lenFilt_q <= 32'h0000_0000;
      skip_q <= 16'h0000;
    end
    else if (apbWr)
    begin
      if (paddr == `EPRX_OFF_CTRL)
        ctrl_q <= pwdata & 32'h0000_0015;
      if (paddr == `EPRX_OFF_LENFILT)
        lenFilt_q <= pwdata & 32'h8000_ffff;
      if (paddr == `EPRX_OFF_SKIP)
        skip_q <= pwdata[15:0];
    end
  end

  // drain side: only committed words are visible, never a transmit path
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      rd_q <= {(AW+1){1'b0}};
      recValid <= 1'b0;
      recData <= 64'h0000_0000_0000_0000;
    end
    else if (!recValid || recReady)
    begin
      recValid <= (rd_q != wrCommit_q);
      if (rd_q != wrCommit_q)
      begin
        recData <= mem[rd_q[AW-1:0]];
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule

// ==== dv/eprx_chk.sv ====
// assertions on the recorder's apb and recording ports
`timescale 1ns/1ps
module eprx_chk
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxValid,
  input wire logic        rxLast,
  input wire logic [63:0] recData,
  input wire logic        recValid,
  input wire logic        recReady
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data not zero");
  a_unmapped_err: assert property (psel && !penable && paddr == 12'h018 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && !penable && paddr == 12'h000 |=> !pslverr)
    else $error("mapped access refused");
  a_rec_hold: assert property (recValid && !recReady |=> recValid && $stable(recData))
    else $error("word changed while stalled");
  // main scenarios reached
  cover property (recValid && !recReady);
  cover property (pslverr);
  cover property (rxValid && rxLast);
endmodule
bind eprx_recorder_rx eprx_chk u_chk
(
  .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxValid(rxValid), .rxLast(rxLast), .recData(recData),
  .recValid(recValid), .recReady(recReady)
);

// ==== dv/eprx_eth_src.sv ====
// ethernet byte source feeding the recorder receive port
`timescale 1ns/1ps
module eprx_eth_src
(
  input  wire logic       clk_sys,
  output logic            rxValid,
  output logic      [7:0] rxData,
  output logic            rxLast
);
  // quiet line at start
  initial
  begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    rxLast  = 1'b0;
  end
  // one packet; data bytes count up from seed, which doubles as a sequence number
  task automatic send(input int len, input logic [7:0] seed, input logic [47:0] src, input logic bad);
    logic [7:0]  b;
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 0; i < len + 26; i++)
    begin
      if (i < 8) b = (i == 7) ? 8'hd5 : 8'h55;
      else if (i < 14) b = 8'h02;
      else if (i < 20) b = src[8*(19-i) +: 8];
      else if (i < 22) b = 8'h08;
      else if (i < len + 22) b = seed + 8'(i - 22);
      else b = ~c[8*(i-len-22) +: 8] ^ {7'h0, bad};
      if (i >= 8 && i < len + 22)
      begin
        c = c ^ {24'h0, b};
        repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
      end
      @(posedge clk_sys);
      rxValid <= 1'b1;
      rxData  <= b;
      rxLast  <= (i == len + 25);
    end
    // one idle cycle, line shows inverse of last byte so stale data never looks valid
    @(posedge clk_sys);
    rxValid <= 1'b0;
    rxLast  <= 1'b0;
    rxData  <= ~b;
  endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the payload recorder
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  localparam logic [47:0] MAC_A = 48'h02_11_22_33_44_55;
  localparam logic [47:0] MAC_B = 48'h02_11_22_33_44_66;
  logic        clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, recReady = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, rxValid, rxLast, recValid, x;
  logic [7:0]  rxData;
  logic [63:0] recData;
  logic [63:0] got[$], exp[$];
  int          err_count = 0, check_count = 0, cyc = 0;
  eprx_recorder_rx DUT (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxValid(rxValid),
    .rxData(rxData), .rxLast(rxLast), .recData(recData), .recValid(recValid), .recReady(recReady));
  eprx_eth_src SRC (.clk_sys(clk_sys), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast));
  always #12.5 clk_sys = ~clk_sys;
  // sink stalls one cycle in four; hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    recReady <= (cyc[1:0] != 2'h3);
    if (recValid === 1'b1 && recReady === 1'b1) got.push_back(recData);
    if (cyc == 60000)
    begin
      err_count++;
      summarize;
    end
  end
  task automatic summarize;
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // request held until pready is seen at a rising edge; the answer is taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    r = prdata;
    x = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(0, a, 32'h0);
    `CHK(r, e)
    `CHK(x, ee)
  endtask
  // expected words: bytes skip..len-1 of client data, zero padded tail
  task automatic expect_pkt(input int len, input int skip, input logic [7:0] seed);
    logic [63:0] w;
    int n;
    w = 0;
    n = 0;
    for (int i = skip; i < len; i++)
    begin
      w[8*n +: 8] = seed + 8'(i);
      n++;
      if (n == 8)
      begin
        exp.push_back(w);
        w = 0;
        n = 0;
      end
    end
    if (n != 0) exp.push_back(w);
  endtask
  task automatic checkw;
    int t;
    t = 0;
    while (got.size() < exp.size() && t < 4000) begin @(posedge clk_sys); t++; end
    repeat (30) @(posedge clk_sys);
    `CHK(got.size(), exp.size())
    for (int i = 0; i < exp.size(); i++) `CHK(got[i], exp[i])
    got.delete(); exp.delete();
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1;
    rd(12'h000, 32'h10, 0);
    rd(12'h018, 32'h0, 1);
    apb(1, 12'h008, 32'h0);
    SRC.send(64, 8'h10, MAC_A, 0);
    expect_pkt(64, 0, 8'h10);
    checkw;
    apb(1, 12'h008, 32'h6);
    SRC.send(46, 8'h20, MAC_A, 0);
    expect_pkt(46, 6, 8'h20);
    SRC.send(46, 8'h30, MAC_A, 1);
    SRC.send(46, 8'h40, MAC_A, 0);
    expect_pkt(46, 6, 8'h40);
    checkw;
    rd(12'h010, 32'h1, 0);
    rd(12'h014, 32'h1, 0);
    rd(12'h00c, 32'h4, 0);
    apb(1, 12'h008, 32'h0);
    apb(1, 12'h004, 32'h8000_0028);
    SRC.send(48, 8'h50, MAC_A, 0);
    SRC.send(40, 8'h60, MAC_A, 0);
    expect_pkt(40, 0, 8'h60);
    checkw;
    apb(1, 12'h004, 32'h0);
    apb(1, 12'h0b8, MAC_A[31:0]);
    apb(1, 12'h0bc, {15'h0, 1'b1, MAC_A[47:32]});
    apb(1, 12'h000, 32'h0);
    SRC.send(40, 8'h70, MAC_B, 0);
    SRC.send(40, 8'h80, MAC_A, 0);
    expect_pkt(40, 0, 8'h80);
    checkw;
    apb(1, 12'h000, 32'h1);
    apb(1, 12'h004, 32'h8000_0028);
    SRC.send(45, 8'h90, MAC_B, 1);
    expect_pkt(45, 0, 8'h90);
    checkw;
    apb(1, 12'h000, 32'h14);
    apb(1, 12'h004, 32'h0);
    rd(12'h000, 32'h14, 0);
    SRC.send(40, 8'hb0, MAC_B, 1);
    expect_pkt(40, 0, 8'hb0);
    SRC.send(8968, 8'ha0, MAC_B, 0);
    expect_pkt(8968, 0, 8'ha0);
    checkw;
    rd(12'h010, 32'h3, 0);
    apb(1, 12'h010, 32'h0);
    rd(12'h010, 32'h0, 0);
    summarize;
  end
endmodule
